// ### src/stair_params.svh
// constants of the staircase trigger and bus parameter block
`ifndef STAIR_PARAMS_SVH
`define STAIR_PARAMS_SVH

// clock and time base
`define CLK_HZ 25000000
`define BASE_TIME_S 1
`define TICK_CYCLES (`CLK_HZ * `BASE_TIME_S)
`define SEC_PER_MIN 6'h3c
`define MIN_PER_HR 6'h3c

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_CFG_TF 8'h04
`define OFF_PAUSE 8'h08
`define OFF_STATUS 8'h0c
`define OFF_PARAMS 8'h10
`define OFF_CFG_THR 8'h14
`define OFF_CFG_RANGE 8'h18

// control register fields
`define CTRL_TF_OBJ 0
`define CTRL_RANGE_OBJ 1
`define CTRL_THR_OBJ 2
`define CTRL_RETRIG 3
`define CTRL_TRIG_OFF 4
`define CTRL_TRIG_PAUSE 5
`define CTRL_MTRIG_PAUSE 6
`define CTRL_BRIGHT_DEP 7
`define CTRL_INIT_READ 8
`define CTRL_INIT_BRIGHT 9
`define CTRL_BASE_LSB 10
`define CTRL_WIDTH 12

// status register fields
`define STAT_RUN 0
`define STAT_PAUSE 1
`define STAT_SW_ON 2
`define STAT_BUS_OK 3
`define STAT_DARK 4

// reset values
`define CTRL_RST 12'h008
`define TF_RST 8'h19
`define RANGE_RST 8'h80
`define THR_RST 16'h0100
`define PAUSE_RST 8'h00

`endif

// ### src/stair_pkg.sv
// types shared by the staircase trigger block
`default_nettype none
package stair_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_PAUSE = 2'b11
    } stair_state_e;

    typedef enum logic [1:0] {
        BASE_SEC = 2'b00,
        BASE_MIN = 2'b01,
        BASE_HR = 2'b10
    } time_base_e;

    typedef enum logic [1:0] {
        OBJ_TF = 2'b00,
        OBJ_RANGE = 2'b01,
        OBJ_THR = 2'b10
    } obj_sel_e;
endpackage : stair_pkg
`default_nettype wire

// ### src/param_if.sv
// carrier between the top and the retained parameter store
`default_nettype none
interface param_if;
    logic wr_en;
    logic [1:0] wr_sel;
    logic [15:0] wr_data;
    logic [7:0] tf;
    logic [7:0] range;
    logic [15:0] thr;

    modport store (
        input wr_en, wr_sel, wr_data,
        output tf, range, thr
    );
    modport user (
        output wr_en, wr_sel, wr_data,
        input tf, range, thr
    );
endinterface : param_if
`default_nettype wire

// ### src/param_store.sv
// retained storage for time factor, range and brightness threshold
`include "stair_params.svh"
`default_nettype none
module param_store import stair_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // parameter port
    param_if.store p
);
    logic [7:0] tf_ff;
    logic [7:0] range_ff;
    logic [15:0] thr_ff;

    // only power-on reset clears these; bus voltage loss does not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tf_ff <= `TF_RST;
        end else if (p.wr_en && p.wr_sel == OBJ_TF) begin
            tf_ff <= p.wr_data[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_ff <= `RANGE_RST;
        end else if (p.wr_en && p.wr_sel == OBJ_RANGE) begin
            range_ff <= p.wr_data[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_ff <= `THR_RST;
        end else if (p.wr_en && p.wr_sel == OBJ_THR) begin
            thr_ff <= p.wr_data;
        end
    end

    assign p.tf = tf_ff;
    assign p.range = range_ff;
    assign p.thr = thr_ff;
endmodule : param_store
`default_nettype wire

// ### src/stair_trigger.sv
// staircase timer with trigger inputs and bus-written parameters
//
// Implementation choices: the register offsets and register access over APB.
`include "stair_params.svh"
`default_nettype none
module stair_trigger import stair_pkg::*; #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus object receive
    input wire logic obj_valid,
    input wire logic [1:0] obj_sel,
    input wire logic [15:0] obj_data,
    // trigger objects
    input wire logic trig_valid,
    input wire logic trig_value,
    input wire logic mtrig_valid,
    input wire logic mtrig_value,
    // local sensing
    input wire logic move_det,
    input wire logic [15:0] bright_meas,
    input wire logic bus_volt,
    // telegram requests
    output logic sw_on,
    output logic send_on,
    output logic send_off,
    output logic req_actual,
    output logic req_status,
    output logic send_bright,
    output logic [7:0] range_out
);
    localparam int PRE_W = 25;

    param_if prm ();

    param_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .p(prm)
    );

    logic [`CTRL_WIDTH-1:0] ctrl_ff;
    logic [7:0] pause_len_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic volt_s1_ff;
    logic volt_s2_ff;
    logic volt_s3_ff;
    logic bus_ok_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [5:0] sec_ff;
    logic [5:0] min_ff;
    logic sec_tick_ff;
    logic min_tick_ff;
    logic hr_tick_ff;
    stair_state_e st_ff;
    stair_state_e nxt_st;
    logic [7:0] tmr_ff;
    logic [7:0] pause_ff;
    logic sw_on_ff;
    logic send_on_ff;
    logic send_off_ff;
    logic req_actual_ff;
    logic req_status_ff;
    logic send_bright_ff;
    logic [7:0] range_out_ff;

    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic base_tick;
    logic dark;
    logic t_hit;
    logic m_hit;
    logic mv_hit;
    logic do_start;
    logic do_retrig;
    logic do_stop;
    logic expire;
    logic volt_rise;
    logic nxt_bus_ok;

    // apb access: one wait cycle, write lands with pready high
    assign apb_wr = psel && penable && pwrite && pready_ff;
    assign apb_rd = psel && penable && !pready_ff;

    always_comb begin
        if (paddr == `OFF_CTRL) begin
            addr_ok = 1'b1;
        end else if (paddr == `OFF_CFG_TF) begin
            addr_ok = 1'b1;
        end else if (paddr == `OFF_PAUSE) begin
            addr_ok = 1'b1;
        end else if (paddr == `OFF_STATUS) begin
            addr_ok = 1'b1;
        end else if (paddr == `OFF_PARAMS) begin
            addr_ok = 1'b1;
        end else if (paddr == `OFF_CFG_THR) begin
            addr_ok = 1'b1;
        end else if (paddr == `OFF_CFG_RANGE) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (apb_rd) begin
            if (paddr == `OFF_CTRL) begin
                prdata_ff <= {20'h0_0000, ctrl_ff};
            end else if (paddr == `OFF_CFG_TF) begin
                prdata_ff <= {24'h00_0000, prm.tf};
            end else if (paddr == `OFF_PAUSE) begin
                prdata_ff <= {24'h00_0000, pause_len_ff};
            end else if (paddr == `OFF_STATUS) begin
                prdata_ff <= {16'h0000, tmr_ff, 3'h0, dark, bus_ok_ff,
                              sw_on_ff, st_ff == ST_PAUSE, st_ff == ST_RUN};
            end else if (paddr == `OFF_PARAMS) begin
                prdata_ff <= {prm.thr, prm.range, prm.tf};
            end else if (paddr == `OFF_CFG_THR) begin
                prdata_ff <= {16'h0000, prm.thr};
            end else if (paddr == `OFF_CFG_RANGE) begin
                prdata_ff <= {24'h00_0000, prm.range};
            end else begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `CTRL_RST;
        end else if (apb_wr && paddr == `OFF_CTRL) begin
            ctrl_ff <= pwdata[`CTRL_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_len_ff <= `PAUSE_RST;
        end else if (apb_wr && paddr == `OFF_PAUSE) begin
            pause_len_ff <= pwdata[7:0];
        end
    end

    // parameter store write: software setup first, else bus object
    always_comb begin
        prm.wr_en = 1'b0;
        prm.wr_sel = OBJ_TF;
        prm.wr_data = 16'h0000;
        if (apb_wr && paddr == `OFF_CFG_TF) begin
            prm.wr_en = 1'b1;
            prm.wr_sel = OBJ_TF;
            prm.wr_data = {8'h00, pwdata[7:0]};
        end else if (apb_wr && paddr == `OFF_CFG_RANGE) begin
            prm.wr_en = 1'b1;
            prm.wr_sel = OBJ_RANGE;
            prm.wr_data = {8'h00, pwdata[7:0]};
        end else if (apb_wr && paddr == `OFF_CFG_THR) begin
            prm.wr_en = 1'b1;
            prm.wr_sel = OBJ_THR;
            prm.wr_data = pwdata[15:0];
        end else if (obj_valid && bus_ok_ff) begin
            prm.wr_sel = obj_sel;
            prm.wr_data = obj_data;
            if (obj_sel == OBJ_TF) begin
                prm.wr_en = ctrl_ff[`CTRL_TF_OBJ];
                prm.wr_data = {8'h00, obj_data[7:0]};
            end else if (obj_sel == OBJ_RANGE) begin
                prm.wr_en = ctrl_ff[`CTRL_RANGE_OBJ];
                prm.wr_data = {8'h00, obj_data[7:0]};
            end else if (obj_sel == OBJ_THR) begin
                prm.wr_en = ctrl_ff[`CTRL_THR_OBJ];
            end
        end
    end

    // one range value feeds every sensor channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_out_ff <= `RANGE_RST;
        end else begin
            range_out_ff <= prm.range;
        end
    end

    // bus voltage pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            volt_s1_ff <= 1'b0;
            volt_s2_ff <= 1'b0;
            volt_s3_ff <= 1'b0;
        end else begin
            volt_s1_ff <= bus_volt;
            volt_s2_ff <= volt_s1_ff;
            volt_s3_ff <= volt_s2_ff;
        end
    end

    always_comb begin
        nxt_bus_ok = bus_ok_ff;
        if (volt_s2_ff == volt_s3_ff) begin
            nxt_bus_ok = volt_s3_ff;
        end
    end

    assign volt_rise = nxt_bus_ok && !bus_ok_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_ok_ff <= 1'b0;
        end else begin
            bus_ok_ff <= nxt_bus_ok;
        end
    end

    // bus voltage return telegrams; failure sends nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_actual_ff <= 1'b0;
            req_status_ff <= 1'b0;
            send_bright_ff <= 1'b0;
        end else begin
            req_actual_ff <= volt_rise && ctrl_ff[`CTRL_INIT_READ];
            req_status_ff <= volt_rise && ctrl_ff[`CTRL_INIT_READ];
            send_bright_ff <= volt_rise && ctrl_ff[`CTRL_INIT_BRIGHT];
        end
    end

    // time base: seconds prescaler, minutes and hours
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= '0;
            sec_tick_ff <= 1'b0;
        end else if (pre_ff == PRE_W'(TICK_CYCLES - 1)) begin
            pre_ff <= '0;
            sec_tick_ff <= 1'b1;
        end else begin
            pre_ff <= pre_ff + 1'b1;
            sec_tick_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_ff <= 6'h00;
            min_ff <= 6'h00;
            min_tick_ff <= 1'b0;
            hr_tick_ff <= 1'b0;
        end else begin
            min_tick_ff <= 1'b0;
            hr_tick_ff <= 1'b0;
            if (sec_tick_ff) begin
                if (sec_ff == `SEC_PER_MIN - 6'h01) begin
                    sec_ff <= 6'h00;
                    min_tick_ff <= 1'b1;
                    if (min_ff == `MIN_PER_HR - 6'h01) begin
                        min_ff <= 6'h00;
                        hr_tick_ff <= 1'b1;
                    end else begin
                        min_ff <= min_ff + 6'h01;
                    end
                end else begin
                    sec_ff <= sec_ff + 6'h01;
                end
            end
        end
    end

    always_comb begin
        case (time_base_e'(ctrl_ff[`CTRL_BASE_LSB +: 2]))
            BASE_MIN: base_tick = min_tick_ff;
            BASE_HR: base_tick = hr_tick_ff;
            default: base_tick = sec_tick_ff;
        endcase
    end

    // trigger decisions; only timer expiry and safety pause expiry act while bus voltage is absent
    assign dark = bright_meas < prm.thr;

    always_comb begin
        t_hit = bus_ok_ff && trig_valid && trig_value &&
                !(st_ff == ST_PAUSE && ctrl_ff[`CTRL_TRIG_PAUSE]);
        m_hit = bus_ok_ff && mtrig_valid && mtrig_value &&
                !(st_ff == ST_PAUSE && ctrl_ff[`CTRL_MTRIG_PAUSE]);
        mv_hit = bus_ok_ff && move_det && st_ff != ST_PAUSE;
        do_stop = bus_ok_ff && trig_valid && !trig_value &&
                  ctrl_ff[`CTRL_TRIG_OFF] && st_ff == ST_RUN;
        do_start = st_ff != ST_RUN && (t_hit ||
                   ((m_hit || mv_hit) &&
                    (!ctrl_ff[`CTRL_BRIGHT_DEP] || dark)));
        do_retrig = st_ff == ST_RUN && sw_on_ff &&
                    ctrl_ff[`CTRL_RETRIG] && (t_hit || m_hit || mv_hit);
        expire = st_ff == ST_RUN && base_tick && tmr_ff <= 8'h01;
    end

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE: begin
                if (do_start) begin
                    nxt_st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (do_stop || (expire && !do_retrig)) begin
                    nxt_st = (pause_len_ff == 8'h00) ? ST_IDLE : ST_PAUSE;
                end
            end
            ST_PAUSE: begin
                if (do_start) begin
                    nxt_st = ST_RUN;
                end else if (sec_tick_ff && pause_ff <= 8'h01) begin
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // staircase timer counts base units of the active factor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_ff <= 8'h00;
        end else if (do_start || (do_retrig && !do_stop)) begin
            tmr_ff <= prm.tf;
        end else if (nxt_st != ST_RUN) begin
            tmr_ff <= 8'h00;
        end else if (base_tick && tmr_ff != 8'h00) begin
            tmr_ff <= tmr_ff - 8'h01;
        end
    end

    // safety pause counts seconds after the timer ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_ff <= 8'h00;
        end else if (st_ff == ST_RUN && nxt_st == ST_PAUSE) begin
            pause_ff <= pause_len_ff;
        end else if (st_ff == ST_PAUSE && sec_tick_ff && pause_ff != 8'h00) begin
            pause_ff <= pause_ff - 8'h01;
        end
    end

    // actuator commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_on_ff <= 1'b0;
            send_on_ff <= 1'b0;
            send_off_ff <= 1'b0;
        end else begin
            send_on_ff <= do_start;
            send_off_ff <= st_ff == ST_RUN && nxt_st != ST_RUN;
            if (do_start) begin
                sw_on_ff <= 1'b1;
            end else if (st_ff == ST_RUN && nxt_st != ST_RUN) begin
                sw_on_ff <= 1'b0;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign sw_on = sw_on_ff;
    assign send_on = send_on_ff;
    assign send_off = send_off_ff;
    assign req_actual = req_actual_ff;
    assign req_status = req_status_ff;
    assign send_bright = send_bright_ff;
    assign range_out = range_out_ff;
endmodule : stair_trigger
`default_nettype wire

// ### dv/stair_trigger_properties.sv
// port assertions of the staircase trigger block
`default_nettype none
module stair_trigger_properties (
    // clock, reset and apb answer
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // trigger side
    input wire logic mtrig_valid,
    input wire logic mtrig_value,
    input wire logic trig_valid,
    input wire logic move_det,
    input wire logic bus_volt,
    // telegram requests
    input wire logic sw_on,
    input wire logic send_on,
    input wire logic send_off,
    input wire logic req_actual,
    input wire logic req_status,
    input wire logic send_bright
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_wait: assert property (
        pready |-> psel && penable && $past(psel && penable))
        else $error("pready without wait state");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_start_sends_on: assert property (
        $rose(sw_on) |-> send_on) else $error("on without telegram");
    a_drop_sends_off: assert property (
        $fell(sw_on) |-> send_off) else $error("off without telegram");
    a_off_clears_out: assert property (
        send_off |-> !sw_on) else $error("off telegram while on");
    a_mtrig_zero_ign: assert property (
        mtrig_valid && !mtrig_value && !trig_valid && !move_det && !sw_on
        |=> !sw_on) else $error("master zero started timer");
    a_fail_no_send: assert property (
        !bus_volt [*6] |-> !req_actual && !req_status && !send_bright)
        else $error("telegram without bus voltage");
    a_fail_no_start: assert property (
        !bus_volt [*6] |=> !$rose(sw_on))
        else $error("start without bus voltage");
    a_req_after_volt: assert property (
        req_actual || req_status |-> $past(bus_volt, 3) && bus_volt)
        else $error("read request too early");
    a_bright_after_volt: assert property (
        send_bright |-> $past(bus_volt, 3) && bus_volt)
        else $error("brightness sent too early");
endmodule : stair_trigger_properties
bind stair_trigger stair_trigger_properties i_props (.pclk, .presetn,
    .psel, .penable, .pready, .pslverr, .mtrig_valid, .mtrig_value,
    .trig_valid, .move_det, .bus_volt, .sw_on, .send_on, .send_off,
    .req_actual, .req_status, .send_bright);
`default_nettype wire

// ### dv/stair_far_side.sv
// slave detector and switch actuator beyond the bus
`default_nettype none
module stair_far_side #(
    parameter int REPEAT_CYCLES = 10
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // slave sensing
    input wire logic moving,
    input wire logic dark_dep,
    input wire logic too_dark,
    input wire logic always_dark,
    // telegrams from the master
    input wire logic send_on,
    input wire logic send_off,
    // slave telegram and actuator state
    output logic slave_on,
    output logic act_on
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            slave_on <= 1'h0;
        end else begin
            slave_on <= 1'h0;
            if (!moving || (dark_dep && !too_dark && !always_dark)) begin
                cnt <= 0;
            end else if (cnt == 0) begin
                slave_on <= 1'h1;
                cnt <= REPEAT_CYCLES - 1;
            end else begin
                cnt <= cnt - 1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_on <= 1'h0;
        end else if (send_on) begin
            act_on <= 1'h1;
        end else if (send_off) begin
            act_on <= 1'h0;
        end
    end
endmodule : stair_far_side
`default_nettype wire

// ### dv/tb_stair_trigger.sv
// self-checking bench for the staircase trigger block
`include "stair_params.svh"
`default_nettype none
module tb_stair_trigger;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 10;
    logic pclk = 1'h0, presetn = 1'h0, bus_volt = 1'h0, moving = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, obj_valid = 1'h0;
    logic [7:0] paddr = 8'h0, range_out, tf, rng;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [1:0] obj_sel = 2'h0;
    logic [15:0] obj_data = 16'h0, bright_meas = 16'h0, thr;
    logic [2:0] ev_v = 3'h0, ev_d = 3'h0;
    logic pready, pslverr, sw_on, send_on, send_off, slave_on, act_on;
    logic req_actual, req_status, send_bright, dd = 1'h0;
    wire logic trig_valid = ev_v[0] | slave_on;
    wire logic trig_value = ev_d[0] | slave_on;
    int miscompares = 0, cmp_count = 0, seed = 32'hcfeca551;
    int n_on = 0, n_off = 0, n_ra = 0, n_rs = 0, n_br = 0;
    always #20 pclk = ~pclk;
    always @(negedge pclk) begin
        n_on <= n_on + send_on;
        n_off <= n_off + send_off;
        n_ra <= n_ra + req_actual;
        n_rs <= n_rs + req_status;
        n_br <= n_br + send_bright;
    end
    stair_trigger #(.TICK_CYCLES(T)) i_stair_trigger (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .obj_valid, .obj_sel, .obj_data, .trig_valid,
        .trig_value, .mtrig_valid(ev_v[1]), .mtrig_value(ev_d[1]),
        .move_det(ev_v[2]), .bright_meas, .bus_volt, .sw_on, .send_on,
        .send_off, .req_actual, .req_status, .send_bright, .range_out);
    stair_far_side #(.REPEAT_CYCLES(T)) i_stair_far_side (.pclk,
        .presetn, .moving, .dark_dep(dd), .too_dark(1'h0),
        .always_dark(1'h0), .send_on, .send_off, .slave_on, .act_on);
    task automatic report_and_stop;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic fail;
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        report_and_stop();
    endtask : fail
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 8);
        if (pready !== 1'h1) fail();
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rdc
    task automatic ev(input int k, input logic v);
        @(posedge pclk);
        ev_v[k] <= 1'h1;
        ev_d[k] <= v;
        @(posedge pclk);
        ev_v[k] <= 1'h0;
        repeat (2) @(negedge pclk);
    endtask : ev
    task automatic obj(input logic [1:0] s, input logic [15:0] d);
        @(posedge pclk);
        obj_valid <= 1'h1;
        obj_sel <= s;
        obj_data <= d;
        @(posedge pclk);
        obj_valid <= 1'h0;
    endtask : obj
    task automatic wait_off(output int c);
        for (c = 0; c < 600 && sw_on === 1'h1; c++) begin
            @(negedge pclk);
        end
        if (c == 600) fail();
        repeat (2) @(negedge pclk);
    endtask : wait_off
    initial begin
        logic [31:0] r;
        logic e;
        int c, k;
        logic [15:0] d;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rdc(`OFF_CTRL, 32'h008);
        rdc(`OFF_CFG_TF, 32'h19);
        rdc(`OFF_PAUSE, 32'h0);
        rdc(`OFF_CFG_RANGE, 32'h80);
        rdc(`OFF_CFG_THR, 32'h0100);
        rdc(`OFF_PARAMS, 32'h0100_8019);
        chk(range_out, 32'h80);
        wr(`OFF_STATUS, 32'hffff_ffff);
        rdc(`OFF_STATUS, 32'h10);
        apb(1'h1, 8'h1c, 32'hffff_ffff, r, e);
        chk(e, 1);
        apb(1'h0, 8'h1c, 32'h0, r, e);
        chk({r[30:0], e}, 1);
        ev(0, 1'h1);
        chk(sw_on, 0);
        wr(`OFF_CTRL, 32'h308);
        @(posedge pclk);
        bus_volt <= 1'h1;
        repeat (10) @(negedge pclk);
        chk({n_ra[7:0], n_rs[7:0], n_br[7:0]}, 32'h01_0101);
        tf = 8'h19;
        rng = 8'h80;
        thr = 16'h0100;
        for (k = 0; k < 3; k++) begin
            d = 16'($random(seed));
            obj(k[1:0], d);
            rdc(`OFF_PARAMS, {thr, rng, tf});
            wr(`OFF_CTRL, 32'h008 | (32'h1 << k));
            d = 16'($random(seed));
            if (k == 0) d = {14'h0, d[1:0] | 2'h2};
            if (k == 0) tf = d[7:0];
            else if (k == 1) rng = d[7:0];
            else thr = d;
            obj(k[1:0], d);
            rdc(`OFF_PARAMS, {thr, rng, tf});
        end
        chk(range_out, rng);
        @(posedge pclk);
        bus_volt <= 1'h0;
        repeat (10) @(posedge pclk);
        bus_volt <= 1'h1;
        repeat (10) @(posedge pclk);
        rdc(`OFF_PARAMS, {thr, rng, tf});
        chk(n_ra + n_br, 2);
        ev(0, 1'h1);
        chk({sw_on, n_on[7:0]}, 32'h101);
        wait_off(c);
        chk(c >= (tf - 1) * T - 2 && c <= tf * T + 2, 1);
        chk({act_on, n_off[7:0]}, 32'h001);
        @(posedge pclk);
        moving <= 1'h1;
        repeat (5) @(negedge pclk);
        c = 0;
        repeat (100) begin
            @(negedge pclk);
            c += (sw_on !== 1'h1);
        end
        chk(c, 0);
        @(posedge pclk);
        moving <= 1'h0;
        wait_off(c);
        chk(act_on, 0);
        wr(`OFF_CTRL, 32'h018);
        ev(0, 1'h1);
        ev(0, 1'h0);
        chk(sw_on, 0);
        wr(`OFF_CTRL, 32'h008);
        ev(0, 1'h1);
        ev(0, 1'h0);
        chk(sw_on, 1);
        wait_off(c);
        wr(`OFF_PAUSE, 32'h3);
        wr(`OFF_CTRL, 32'h038);
        ev(0, 1'h1);
        ev(0, 1'h0);
        ev(0, 1'h1);
        chk(sw_on, 0);
        ev(1, 1'h1);
        chk(sw_on, 1);
        wait_off(c);
        wr(`OFF_PAUSE, 32'h0);
        repeat (40) @(negedge pclk);
        wr(`OFF_CTRL, 32'h088);
        wr(`OFF_CFG_THR, 32'h0100);
        @(posedge pclk);
        bright_meas <= 16'h0100 + 16'($random(seed) & 32'hff);
        ev(1, 1'h1);
        ev(2, 1'h1);
        ev(1, 1'h0);
        chk(sw_on, 0);
        ev(0, 1'h1);
        chk(sw_on, 1);
        wait_off(c);
        @(posedge pclk);
        bright_meas <= 16'($random(seed) & 32'hff);
        ev(1, 1'h1);
        chk(sw_on, 1);
        wait_off(c);
        @(posedge pclk);
        dd <= 1'h1;
        moving <= 1'h1;
        c = 0;
        repeat (50) begin
            @(negedge pclk);
            c += (sw_on === 1'h1);
        end
        chk(c, 0);
        report_and_stop();
    end
endmodule : tb_stair_trigger
`default_nettype wire
